// [sas_defines.svh]
// Purpose: Register offsets, fields, reset values and timing counts of the converter sequencer
// Assumes: One byte-wide register port on the processor bus, system clock in states
// Notes:   Counts are in states (system clock cycles)
`ifndef SAS_DEFINES_SVH
`define SAS_DEFINES_SVH

`define SAS_ADDR_RESULT_A   16'hFFE0
`define SAS_ADDR_RESULT_B   16'hFFE2
`define SAS_ADDR_RESULT_C   16'hFFE4
`define SAS_ADDR_RESULT_D   16'hFFE6
`define SAS_ADDR_CTRL_STAT  16'hFFE8
`define SAS_ADDR_TRIG_CTRL  16'hFFEA

`define SAS_BIT_DONE        7
`define SAS_BIT_IRQ_EN      6
`define SAS_BIT_GO          5
`define SAS_BIT_SCAN        4
`define SAS_BIT_SPEED       3
`define SAS_BIT_GROUP       2
`define SAS_BIT_TRIG_EN     7

`define SAS_CTRL_RESET      8'h00
`define SAS_TRIG_RESET      8'h7E
`define SAS_TRIG_FIXED      8'h7E

`define SAS_SAMPLE_SLOW     63
`define SAS_SAMPLE_FAST     31
`define SAS_SYNC_PERIOD_SLOW 16
`define SAS_SYNC_PERIOD_FAST 8
`define SAS_SYNC_BASE_SLOW  18
`define SAS_SYNC_BASE_FAST  10
`define SAS_STEPS           8
`define SAS_TOTAL_SLOW_MIN  227
`define SAS_TOTAL_FAST_MIN  115
`define SAS_SCAN_EXTRA_SLOW 32
`define SAS_SCAN_EXTRA_FAST 16
`define SAS_SCAN_NEXT_SLOW  256
`define SAS_SCAN_NEXT_FAST  128

`endif

// [sas_pkg.sv]
// Purpose: Types shared by the converter sequencer files
// Assumes: Nothing beyond the defines header
// Notes:   States carry no explicit codes
package sas_pkg;
   typedef enum logic [2:0] {SAS_IDLE, SAS_SYNC, SAS_SAMPLE, SAS_STEP, SAS_TAIL} sas_state_t;

   typedef struct packed {
      logic        done_flag;
      logic        irq_enable;
      logic        go;
      logic        scan;
      logic        speed;
      logic [2:0]  chan;
   } sas_ctrl_t;

   typedef struct packed {
      logic        wr;
      logic [1:0]  idx;
      logic [7:0]  data;
   } sas_result_wr_t;
endpackage

// [sas_result_mem.sv]
// Purpose: Four result registers shared by the two input groups
// Assumes: One write and one read port
// Notes:   Read data is registered, so reads return one cycle after the address
module sas_result_mem #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input  wire logic                      clk,
   input  wire logic                      rst,
   // Write side
   input  wire logic                      wr,
   input  wire logic [$clog2(DEPTH)-1:0]  wr_idx,
   input  wire logic [WIDTH-1:0]          wr_data,
   // Read side
   input  wire logic [$clog2(DEPTH)-1:0]  rd_idx,
   output logic      [WIDTH-1:0]          rd_data
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < DEPTH; i++) mem[i] <= '0;
         rd_data <= '0;
      end else begin
         if (wr) mem[wr_idx] <= wr_data;
         rd_data <= mem[rd_idx];
      end
   end
endmodule

// [sas_sequencer.sv]
// Purpose: Control and sequencing of an 8-bit successive-approximation converter
// Assumes: Byte register port with one-cycle registered read data; comparator is outside
// Notes:   Only the digital sequencing is here; analog sampling is signalled by sample_active
//
// Summary of operation
// - Eight approximation steps resolve each sample into a code 00 to FF.
// - Single mode converts the selected channel once whenever go becomes one.
// - Go reads one during single conversion and hardware clears it at the end.
// - Single completion sets the done flag; interrupt raised when also enabled.
// - Done flag clears only by reset, standby, or reading it set, then writing zero there.
// - One write may change mode and channel and start with new settings.
// - Single end stores result per channel, sets done, clears go, stops.
// - Scan start begins at input 0 or input 4 according to group bit.
// - Scan moves to the next channel right after the previous one ends.
// - Scan repeats over the selected channels while go stays one.
// - After each full scan pass, set done, interrupt if enabled, restart.
// - Setting go again after it was cleared restarts scan from the first group channel.
// - After go, sync delay then sample 63 slow or 31 fast states.
// - Sync delay spans 18 to 33 slow or 10 to 17 fast states.
// - Single conversion lasts 227 to 242 slow or 115 to 122 fast states.
// - First scan conversion lasts 259 to 274 slow or 131 to 138 fast.
// - Later scan conversions last exactly 256 slow or 128 fast states.
// - With trigger enabled, falling edge on the start pin sets go.
// - Four result registers, each shared by inputs 0/4, 1/5, 2/6, 3/7.
// - Top select bit picks group; low bits pick one input or scan range.
// - Go is also cleared by reset or standby, stopping any scan.
`include "sas_defines.svh"
module sas_sequencer (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst,
   // Register port
   input  wire logic [15:0]           reg_addr,
   input  wire logic                  reg_rd,
   input  wire logic                  reg_wr,
   input  wire logic [7:0]            reg_wdata,
   output logic      [7:0]            reg_rdata,
   // System
   input  wire logic                  standby,
   input  wire logic                  external_start_pin,
   // Analog front end
   input  wire logic                  comparator_high,
   output logic                       sample_active,
   output logic      [2:0]            analog_channel,
   output logic      [7:0]            trial_code,
   // Interrupt
   output logic                       done_irq_request
);
   import sas_pkg::*;

   sas_ctrl_t       ctrl;
   logic            external_start_enable;
   sas_state_t      state;
   logic [8:0]      cnt;
   logic [3:0]      phase;
   logic [2:0]      step;
   logic [7:0]      sar;
   logic [1:0]      chan_pos;
   logic            first_conv;
   logic            done_armed;
   logic            pin_prev;
   logic [7:0]      mem_rdata;
   logic [1:0]      rd_idx;
   logic            rd_ctrl;
   logic            rd_trig;
   logic            rd_mem;

   // Trigger edge and start conditions
   wire trig_edge   = pin_prev & ~external_start_pin;
   wire trig_set    = external_start_enable & trig_edge;
   wire wr_ctrl     = reg_wr & (reg_addr == `SAS_ADDR_CTRL_STAT);
   wire wr_trig     = reg_wr & (reg_addr == `SAS_ADDR_TRIG_CTRL);
   wire sw_go       = wr_ctrl & reg_wdata[`SAS_BIT_GO];
   wire sw_stop     = wr_ctrl & ~reg_wdata[`SAS_BIT_GO];
   wire go_rise     = (sw_go | trig_set) & ~ctrl.go;
   wire slow        = ~ctrl.speed;
   // Phase counter divides clock so that the sync delay varies with alignment
   wire [3:0] phase_max = slow ? 4'hF : 4'h7;
   wire [8:0] sync_len  = slow ? 9'(`SAS_SYNC_BASE_SLOW) : 9'(`SAS_SYNC_BASE_FAST);
   wire [8:0] samp_len  = slow ? 9'(`SAS_SAMPLE_SLOW) : 9'(`SAS_SAMPLE_FAST);
   wire [8:0] single_tail = slow ? 9'(`SAS_TOTAL_SLOW_MIN - `SAS_SYNC_BASE_SLOW - `SAS_SAMPLE_SLOW
                                      - `SAS_STEPS * `SAS_SYNC_PERIOD_SLOW)
                                 : 9'(`SAS_TOTAL_FAST_MIN - `SAS_SYNC_BASE_FAST - `SAS_SAMPLE_FAST
                                      - `SAS_STEPS * `SAS_SYNC_PERIOD_FAST);
   wire [8:0] scan_extra = slow ? 9'(`SAS_SCAN_EXTRA_SLOW) : 9'(`SAS_SCAN_EXTRA_FAST);
   wire [8:0] step_len  = slow ? 9'(`SAS_SYNC_PERIOD_SLOW) : 9'(`SAS_SYNC_PERIOD_FAST);
   // Later scan conversions: sample plus steps plus tail equals the fixed period
   wire [8:0] next_tail = (slow ? 9'(`SAS_SCAN_NEXT_SLOW) : 9'(`SAS_SCAN_NEXT_FAST))
                          - samp_len - 9'(`SAS_STEPS) * step_len;
   wire [8:0] tail_len  = ~ctrl.scan ? single_tail
                        : first_conv ? single_tail + scan_extra : next_tail;
   wire [1:0] last_pos  = ctrl.chan[1:0];
   wire       conv_end  = (state == SAS_TAIL) && (cnt == tail_len - 9'h001);
   wire [7:0] final_code = sar;
   wire       pass_end  = conv_end & (~ctrl.scan | (chan_pos == last_pos));
   wire       go_abort  = sw_stop | standby;
   wire [1:0] cur_pos   = ctrl.scan ? chan_pos : ctrl.chan[1:0];
   wire       clear_done = wr_ctrl & done_armed & ~reg_wdata[`SAS_BIT_DONE];

   // Go bit, control fields and done flag
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl <= sas_ctrl_t'(`SAS_CTRL_RESET);
         external_start_enable <= 1'b0;
         done_armed <= 1'b0;
      end else if (standby) begin
         ctrl <= sas_ctrl_t'(`SAS_CTRL_RESET);
         external_start_enable <= 1'b0;
         done_armed <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ctrl.irq_enable <= reg_wdata[`SAS_BIT_IRQ_EN];
            ctrl.scan <= reg_wdata[`SAS_BIT_SCAN];
            ctrl.speed <= reg_wdata[`SAS_BIT_SPEED];
            ctrl.chan <= reg_wdata[2:0];
         end
         if (wr_trig) external_start_enable <= reg_wdata[`SAS_BIT_TRIG_EN];
         // A stop write wins over a trigger edge, matching the sequencer's abort path
         if (sw_stop) ctrl.go <= 1'b0;
         else if (go_rise) ctrl.go <= 1'b1;
         else if (conv_end & ~ctrl.scan) ctrl.go <= 1'b0;
         // A completion in the same cycle as a clear keeps the flag set
         if (pass_end) ctrl.done_flag <= 1'b1;
         else if (clear_done) ctrl.done_flag <= 1'b0;
         if (reg_rd & rd_ctrl & ctrl.done_flag) done_armed <= 1'b1;
         else if (clear_done) done_armed <= 1'b0;
      end
   end

   // Conversion sequence
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= SAS_IDLE;
         cnt <= 9'h000;
         phase <= 4'h0;
         step <= 3'h0;
         sar <= 8'h00;
         chan_pos <= 2'h0;
         first_conv <= 1'b0;
         pin_prev <= 1'b1;
      end else begin
         pin_prev <= external_start_pin;
         phase <= (phase >= phase_max) ? 4'h0 : phase + 4'h1;
         cnt <= cnt + 9'h001;
         if (go_abort | go_rise) begin
            state <= go_rise & ~go_abort ? SAS_SYNC : SAS_IDLE;
            chan_pos <= 2'h0;
            first_conv <= 1'b1;
            cnt <= 9'h000;
         end else begin
            unique case (state)
               SAS_IDLE: cnt <= 9'h000;
               SAS_SYNC:
                  if (cnt >= sync_len - 9'h001 && phase == 4'h0) begin
                     state <= SAS_SAMPLE;
                     cnt <= 9'h000;
                  end
               SAS_SAMPLE:
                  if (cnt == samp_len - 9'h001) begin
                     state <= SAS_STEP;
                     cnt <= 9'h000;
                     step <= 3'h7;
                     sar <= 8'h80;
                  end
               SAS_STEP:
                  if (cnt == step_len - 9'h001) begin
                     cnt <= 9'h000;
                     // Keep the trial bit when input is above the trial level
                     sar[step] <= comparator_high;
                     if (step == 3'h0) state <= SAS_TAIL;
                     else begin
                        sar[step - 3'h1] <= 1'b1;
                        step <= step - 3'h1;
                     end
                  end
               SAS_TAIL:
                  if (conv_end) begin
                     cnt <= 9'h000;
                     first_conv <= 1'b0;
                     if (~ctrl.scan) state <= SAS_IDLE;
                     else begin
                        state <= SAS_SAMPLE;
                        chan_pos <= (chan_pos == last_pos) ? 2'h0 : chan_pos + 2'h1;
                     end
                  end
            endcase
         end
      end
   end

   // Result storage and reads
   assign rd_ctrl = reg_addr == `SAS_ADDR_CTRL_STAT;
   assign rd_trig = reg_addr == `SAS_ADDR_TRIG_CTRL;
   assign rd_mem  = reg_addr[15:3] == 13'(`SAS_ADDR_RESULT_A >> 3) && ~reg_addr[0];
   assign rd_idx  = reg_addr[2:1];
   logic [1:0] rsel;
   logic [7:0] status_q;

   sas_result_mem #(.WIDTH(8), .DEPTH(4)) u_mem (
      .clk     (clk),
      .rst     (rst | standby),
      .wr      (conv_end),
      .wr_idx  (cur_pos),
      .wr_data (final_code),
      .rd_idx  (rd_idx),
      .rd_data (mem_rdata)
   );

   always_ff @(posedge clk) begin
      if (rst) begin
         rsel <= 2'h0;
         status_q <= 8'h00;
      end else begin
         rsel <= rd_ctrl ? 2'h1 : rd_trig ? 2'h2 : rd_mem ? 2'h3 : 2'h0;
         status_q <= rd_ctrl ? 8'(ctrl)
                   : {external_start_enable, 7'(`SAS_TRIG_FIXED)};
      end
   end

   assign reg_rdata = (rsel == 2'h3) ? mem_rdata : (rsel == 2'h0) ? 8'h00 : status_q;
   assign done_irq_request = ctrl.done_flag & ctrl.irq_enable;
   assign sample_active  = state == SAS_SAMPLE;
   assign analog_channel = {ctrl.chan[2], cur_pos};
   assign trial_code     = sar;
endmodule

// [sas_monitor.sv]
// Purpose: Port assertions for the converter sequencer
// Assumes: One clock, synchronous reset
// Notes:   Gap check relies on idle spells over 260 cycles between runs
module sas_monitor (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // Register port
   input wire logic [15:0] reg_addr,
   input wire logic        reg_wr,
   input wire logic [7:0]  reg_wdata,
   input wire logic [7:0]  reg_rdata,
   // System and analog
   input wire logic        standby,
   input wire logic        sample_active,
   input wire logic        done_irq_request
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] run;
   logic [8:0] gap;
   logic [8:0] pgap;
   logic       sa_q;
   logic       stop_q;
   wire        rise = sample_active && !sa_q;
   // A software stop may cut a sampling window short, so that window is not judged
   wire        stop_wr = reg_wr && reg_addr == 16'hFFE8 && !reg_wdata[5];
   // Saturating gap so the first rise after idle is never judged
   always_ff @(posedge clk) begin
      if (rst || standby) begin
         run  <= 8'h00;
         gap  <= 9'h1FF;
         pgap <= 9'h1FF;
         sa_q <= 1'b0;
         stop_q <= 1'b0;
      end else begin
         run  <= sample_active ? run + 8'h01 : 8'h00;
         sa_q <= sample_active;
         stop_q <= stop_wr;
         gap  <= rise ? 9'h001 : (gap == 9'h1FF ? gap : gap + 9'h001);
         pgap <= rise ? gap : pgap;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_ctrl_rd;
      reg_addr == 16'hFFE8 && !reg_wr && !standby;
   endsequence
   sequence s_go_single;
      reg_wr && reg_addr == 16'hFFE8 && reg_wdata[6:3] == 4'hC && !done_irq_request;
   endsequence
   property p_standby;
      standby |=> !done_irq_request && !sample_active;
   endproperty
   a_standby: assert property (p_standby) else $error("activity after standby");
   property p_sample_len;
      !sample_active && sa_q && !stop_q |-> run == 8'h3F || run == 8'h1F;
   endproperty
   a_sample_len: assert property (p_sample_len) else $error("sampling length");
   property p_trig_read;
      reg_addr == 16'hFFEA |=> reg_rdata[6:0] == 7'h7E;
   endproperty
   a_trig_read: assert property (p_trig_read) else $error("trigger fixed bits");
   property p_unmapped;
      reg_addr[15:4] != 12'hFFE |=> reg_rdata == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read");
   property p_go_reads;
      sample_active ##0 s_ctrl_rd |=> reg_rdata[5];
   endproperty
   a_go_reads: assert property (p_go_reads) else $error("go low in conversion");
   property p_irq_flag;
      done_irq_request ##0 s_ctrl_rd |=> reg_rdata[7:6] == 2'h3;
   endproperty
   a_irq_flag: assert property (p_irq_flag) else $error("request without flag");
   property p_single;
      s_go_single |-> ##[226:244] $rose(done_irq_request);
   endproperty
   a_single: assert property (p_single) else $error("single duration");
   property p_gap;
      rise && gap < 9'h104 && pgap < 9'h104 |-> gap == 9'h100 || gap == 9'h080;
   endproperty
   a_gap: assert property (p_gap) else $error("scan spacing");
endmodule

bind sas_sequencer sas_monitor mon (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .standby(standby), .sample_active(sample_active),
   .done_irq_request(done_irq_request));

// [sas_analog_model.sv]
// Purpose: Analog inputs and trigger source beside the sequencer
// Assumes: Ideal comparator against a held sample
// Notes:   Bench sets levels through the level array
module sas_analog_model (
   // Clock
   input wire logic       clk,
   // Sequencer side
   input wire logic       sample_active,
   input wire logic [2:0] analog_channel,
   input wire logic [7:0] trial_code,
   output logic           comparator_high,
   output logic           external_start_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] level [8];
   logic [7:0] held;
   always_ff @(posedge clk)
      if (sample_active)
         held <= level[analog_channel];
   assign comparator_high = held >= trial_code;
   initial external_start_pin = 1'b1;
   task automatic pulse();
      @(posedge clk);
      #1 external_start_pin = 1'b0;
      repeat (3) @(posedge clk);
      #1 external_start_pin = 1'b1;
   endtask
endmodule

// [tb_top.sv]
// Purpose: Self-checking bench for the converter sequencer
// Assumes: Partner model supplies levels and trigger pin
// Notes:   Idle spells of 300 cycles keep runs apart for the monitor
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [15:0] reg_addr = 16'h0000;
   logic        reg_rd = 1'b0;
   logic        reg_wr = 1'b0;
   logic [7:0]  reg_wdata = 8'h00;
   logic        standby = 1'b0;
   logic [7:0]  reg_rdata, trial_code;
   logic [2:0]  analog_channel;
   logic        sample_active, comparator_high, external_start_pin, done_irq_request;
   int          miscompares = 0;
   int          checked = 0;
   always #5 clk = ~clk;
   sas_sequencer uut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .standby(standby), .external_start_pin(external_start_pin),
      .comparator_high(comparator_high), .sample_active(sample_active), .analog_channel(analog_channel),
      .trial_code(trial_code), .done_irq_request(done_irq_request));
   sas_analog_model am (.clk(clk), .sample_active(sample_active), .analog_channel(analog_channel),
      .trial_code(trial_code), .comparator_high(comparator_high), .external_start_pin(external_start_pin));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: saw %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      #1 reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clk);
      #1 reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      @(posedge clk);
      #1 reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk);
      #1 reg_rd = 1'b0;
      chk(reg_rdata, exp);
   endtask
   // Counts cycles to the request; running out counts as a miss
   task automatic wait_irq(input int lo, input int hi);
      int n = 0;
      while (done_irq_request !== 1'b1 && n < hi) begin
         @(posedge clk);
         #1 n++;
      end
      chk(8'(n >= lo && n < hi), 8'h01);
   endtask
   task automatic first_ch(input logic [2:0] c);
      @(posedge sample_active);
      #1 chk(8'(analog_channel), 8'(c));
   endtask
   task automatic complete_run();
      $display("comparisons %0d, mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic t_regs();
      for (int i = 0; i < 8; i += 2)
         rd(16'hFFE0 + 16'(i), 8'h00);
      wr(16'hFFE8, 8'h80);
      rd(16'hFFE8, 8'h00);
      wr(16'hFFEA, 8'hFF);
      rd(16'hFFEA, 8'hFE);
      wr(16'hFFEA, 8'h00);
      rd(16'hFFE1, 8'h00);
      $display("regs done");
   endtask
   task automatic t_single();
      am.level[1] = 8'hFF;
      am.level[6] = 8'h3C;
      wr(16'hFFE8, 8'h61);
      rd(16'hFFE8, 8'h61);
      wait_irq(222, 243);
      rd(16'hFFE8, 8'hC1);
      rd(16'hFFE2, 8'hFF);
      wr(16'hFFE8, 8'h41);
      chk(8'(done_irq_request), 8'h00);
      wr(16'hFFE8, 8'h6E);
      wait_irq(112, 124);
      wr(16'hFFE8, 8'h40);
      rd(16'hFFE8, 8'hC0);
      wr(16'hFFE8, 8'h40);
      rd(16'hFFE8, 8'h40);
      rd(16'hFFE4, 8'h3C);
      repeat (300) @(posedge clk);
      $display("single done");
   endtask
   task automatic t_scan();
      am.level[0] = 8'h12;
      am.level[1] = 8'h34;
      am.level[2] = 8'h56;
      wr(16'hFFE8, 8'h72);
      first_ch(3'h0);
      wait_irq(730, 790);
      rd(16'hFFE8, 8'hF2);
      rd(16'hFFE0, 8'h12);
      rd(16'hFFE2, 8'h34);
      rd(16'hFFE4, 8'h56);
      rd(16'hFFE6, 8'h00);
      am.level[0] = 8'h99;
      // Clears the flag while go stays set, so scanning must carry on
      wr(16'hFFE8, 8'h72);
      wait_irq(750, 762);
      rd(16'hFFE0, 8'h99);
      repeat (300) @(posedge clk);
      wr(16'hFFE8, 8'h52);
      repeat (300) @(posedge clk);
      wr(16'hFFE8, 8'h72);
      first_ch(3'h0);
      wr(16'hFFE8, 8'h52);
      repeat (300) @(posedge clk);
      am.level[4] = 8'h21;
      am.level[5] = 8'h43;
      rd(16'hFFE8, 8'hD2);
      wr(16'hFFE8, 8'h7D);
      first_ch(3'h4);
      wait_irq(235, 270);
      rd(16'hFFE0, 8'h21);
      rd(16'hFFE2, 8'h43);
      wr(16'hFFE8, 8'h5D);
      repeat (300) @(posedge clk);
      $display("scan done");
   endtask
   task automatic t_trig();
      am.level[3] = 8'hA5;
      rd(16'hFFE8, 8'hDD);
      wr(16'hFFE8, 8'h43);
      wr(16'hFFEA, 8'h80);
      am.pulse();
      wait_irq(218, 245);
      rd(16'hFFE6, 8'hA5);
      rd(16'hFFE8, 8'hC3);
      wr(16'hFFE8, 8'h43);
      wr(16'hFFEA, 8'h00);
      am.pulse();
      repeat (300) @(posedge clk);
      chk(8'(done_irq_request), 8'h00);
      $display("trigger done");
   endtask
   task automatic t_standby();
      wr(16'hFFEA, 8'h80);
      wr(16'hFFE8, 8'h70);
      repeat (100) @(posedge clk);
      #1 standby = 1'b1;
      @(posedge clk);
      #1 standby = 1'b0;
      rd(16'hFFE8, 8'h00);
      rd(16'hFFEA, 8'h7E);
      rd(16'hFFE0, 8'h00);
      $display("standby done");
   endtask
   initial begin
      #400000;
      miscompares++;
      complete_run();
   end
   initial begin
      repeat (3) @(posedge clk);
      #1 rst = 1'b0;
      t_regs();
      t_single();
      t_scan();
      t_trig();
      t_standby();
      complete_run();
   end
endmodule
